// [core/dpbram_consts.svh]
// Constants of the dual-port block RAM: geometry, lane masks, reset values
`ifndef DPBRAM_CONSTS_SVH
`define DPBRAM_CONSTS_SVH

// ****************************************************************
// Array geometry, 4096 bits in every shape
// ****************************************************************
`define DPBRAM_ROWS 256
`define DPBRAM_ROW_W 8
`define DPBRAM_DATA_W 16
`define DPBRAM_ADDR_W 11
`define DPBRAM_BITS 4096

// ****************************************************************
// Lane masks of the three narrow shapes
// ****************************************************************
`define DPBRAM_LANE8_MASK 16'h00ff
`define DPBRAM_LANE4_MASK 16'h000f
`define DPBRAM_LANE2_MASK 16'h0003

// ****************************************************************
// Reset values
// ****************************************************************
`define DPBRAM_RDATA_RST 16'h0000
`define DPBRAM_MEM_INIT 4096'h0

`endif

// [core/dpbram_pkg.sv]
// Types shared by the dual-port block RAM files
`default_nettype none

package dpbram_pkg;

  // Depth/width shape of the array
  typedef enum logic [1:0] {
    DPBRAM_S256X16,
    DPBRAM_S512X8,
    DPBRAM_S1024X4,
    DPBRAM_S2048X2
  } dpbram_shape_t;

  // Clock edge variant of write and read sides
  typedef enum logic [1:0] {
    DPBRAM_RISING_BOTH,
    DPBRAM_FALLING_RD_VARIANT,
    DPBRAM_FALLING_WR_VARIANT,
    DPBRAM_BOTH_FALLING_VARIANT
  } dpbram_variant_t;

endpackage

`default_nettype wire

// [core/dpbram_port_reg.sv]
// Input register stage at the array boundary, with optional one-cycle delay
`timescale 1ns/1ps
`default_nettype none

module dpbram_port_reg #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic gate,
  input wire logic req,
  input wire logic falling,
  input wire logic [W-1:0] d,
  output logic op,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic op1;
    logic [W-1:0] d1;
    logic op2;
    logic [W-1:0] d2;
  } dpbram_port_st_t;

  dpbram_port_st_t st_r;
  dpbram_port_st_t st_nxt;

  // Gate low freezes the captured word, as a stopped clock would
  always_comb begin
    st_nxt = st_r;
    st_nxt.op1 = gate & req;
    if (gate) begin
      st_nxt.d1 = d;
    end
    st_nxt.op2 = st_r.op1;
    st_nxt.d2 = st_r.d1;
  end

  // Cleared on reset so no stale request fires after release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Falling-edge variant lands one stage later in this single-clock model
  assign op = falling ? st_r.op2 : st_r.op1;
  assign q = falling ? st_r.d2 : st_r.d1;

endmodule

`default_nettype wire

// [core/dpbram_top.sv]
// Dual-port block RAM: one write port, one read port, four shapes
// Function
// - Shapes 256x16, 512x8, 1024x4, 2048x2
// - Write address width follows shape
// - Read address selects word onto read data
// - Bit mask in 256x16 shape, 1 protects
// - Four clock edge variants, rising default
// - Data and addresses registered at array
// - Contents preloaded before start-up
// - Separate write and read ports
`timescale 1ns/1ps
`default_nettype none
`include "dpbram_consts.svh"

module dpbram_top #(
  parameter logic [`DPBRAM_BITS-1:0] MEM_INIT = `DPBRAM_MEM_INIT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire dpbram_pkg::dpbram_shape_t shape,
  input wire dpbram_pkg::dpbram_variant_t variant,
  input wire logic [`DPBRAM_ADDR_W-1:0] wr_addr,
  input wire logic [`DPBRAM_DATA_W-1:0] wr_data,
  input wire logic [`DPBRAM_DATA_W-1:0] wr_mask,
  input wire logic wr_strobe,
  input wire logic wr_clk_gate,
  input wire logic [`DPBRAM_ADDR_W-1:0] rd_addr,
  input wire logic rd_strobe,
  input wire logic rd_clk_gate,
  output logic [`DPBRAM_DATA_W-1:0] rd_data
);
  import dpbram_pkg::*;

  localparam int WW = `DPBRAM_ADDR_W + 2 * `DPBRAM_DATA_W;

  typedef struct packed {
    logic [`DPBRAM_ROWS-1:0][`DPBRAM_DATA_W-1:0] mem;
    logic [`DPBRAM_DATA_W-1:0] rd_data;
  } dpbram_st_t;

  dpbram_st_t st_r;
  dpbram_st_t st_nxt;

  logic wr_fall;
  logic rd_fall;
  logic wr_op;
  logic rd_op;
  logic [WW-1:0] wr_q;
  logic [`DPBRAM_ADDR_W-1:0] rd_q;
  logic [`DPBRAM_ADDR_W-1:0] wq_addr;
  logic [`DPBRAM_DATA_W-1:0] wq_data;
  logic [`DPBRAM_DATA_W-1:0] wq_mask;
  logic [`DPBRAM_ROW_W-1:0] w_row;
  logic [`DPBRAM_ROW_W-1:0] r_row;
  logic [3:0] w_sh;
  logic [3:0] r_sh;
  logic [`DPBRAM_DATA_W-1:0] w_bits;
  logic [`DPBRAM_DATA_W-1:0] w_rep;
  logic [`DPBRAM_DATA_W-1:0] r_word;

  // ****************************************************************
  // Edge variants
  // ****************************************************************
  // Opposite edge is modelled as one extra boundary stage on that side
  assign wr_fall = (variant == DPBRAM_FALLING_WR_VARIANT) ||
                   (variant == DPBRAM_BOTH_FALLING_VARIANT);
  assign rd_fall = (variant == DPBRAM_FALLING_RD_VARIANT) ||
                   (variant == DPBRAM_BOTH_FALLING_VARIANT);

  // ****************************************************************
  // Boundary registers, one per port
  // ****************************************************************
  // Independent write and read ports, each captured before use
  dpbram_port_reg #(.W(WW)) u_wr_reg (
    .clock(clock),
    .arst_n(arst_n),
    .gate(wr_clk_gate),
    .req(wr_strobe),
    .falling(wr_fall),
    .d({wr_addr, wr_data, wr_mask}),
    .op(wr_op),
    .q(wr_q)
  );

  dpbram_port_reg #(.W(`DPBRAM_ADDR_W)) u_rd_reg (
    .clock(clock),
    .arst_n(arst_n),
    .gate(rd_clk_gate),
    .req(rd_strobe),
    .falling(rd_fall),
    .d(rd_addr),
    .op(rd_op),
    .q(rd_q)
  );

  // Split the captured write word back into address, data and mask
  assign wq_addr = wr_q[WW-1 -: `DPBRAM_ADDR_W];
  assign wq_data = wr_q[2*`DPBRAM_DATA_W-1 -: `DPBRAM_DATA_W];
  assign wq_mask = wr_q[`DPBRAM_DATA_W-1:0];

  // ****************************************************************
  // Address decode into row and lane
  // ****************************************************************
  // Upper address bits beyond the shape's width are ignored
  function automatic logic [11:0] dpbram_decode(input dpbram_shape_t s,
                                                input logic [`DPBRAM_ADDR_W-1:0] a);
    logic [11:0] r;
    r = '0;
    unique case (s)
      DPBRAM_S256X16: r = {a[7:0], 4'h0};
      DPBRAM_S512X8: r = {a[8:1], a[0], 3'h0};
      DPBRAM_S1024X4: r = {a[9:2], a[1:0], 2'h0};
      DPBRAM_S2048X2: r = {a[10:3], a[2:0], 1'b0};
    endcase
    return r;
  endfunction

  assign {w_row, w_sh} = dpbram_decode(shape, wq_addr);
  assign {r_row, r_sh} = dpbram_decode(shape, rd_q);

  // ****************************************************************
  // Write lane enables and replicated data
  // ****************************************************************
  // Mask port only acts in the 16-bit shape; 1 protects the bit
  always_comb begin
    w_bits = '0;
    w_rep = '0;
    unique case (shape)
      DPBRAM_S256X16: begin
        w_bits = ~wq_mask;
        w_rep = wq_data;
      end
      DPBRAM_S512X8: begin
        w_bits = `DPBRAM_LANE8_MASK << w_sh;
        w_rep = {2{wq_data[7:0]}};
      end
      DPBRAM_S1024X4: begin
        w_bits = `DPBRAM_LANE4_MASK << w_sh;
        w_rep = {4{wq_data[3:0]}};
      end
      DPBRAM_S2048X2: begin
        w_bits = `DPBRAM_LANE2_MASK << w_sh;
        w_rep = {8{wq_data[1:0]}};
      end
    endcase
  end

  // ****************************************************************
  // Read lane extraction
  // ****************************************************************
  // Narrow shapes return the lane in the low bits, zeros above
  always_comb begin
    r_word = '0;
    unique case (shape)
      DPBRAM_S256X16: r_word = st_r.mem[r_row];
      DPBRAM_S512X8: r_word = (st_r.mem[r_row] >> r_sh) & `DPBRAM_LANE8_MASK;
      DPBRAM_S1024X4: r_word = (st_r.mem[r_row] >> r_sh) & `DPBRAM_LANE4_MASK;
      DPBRAM_S2048X2: r_word = (st_r.mem[r_row] >> r_sh) & `DPBRAM_LANE2_MASK;
    endcase
  end

  // ****************************************************************
  // Array and read register
  // ****************************************************************
  // Read sees the old word when write and read hit the same row together
  always_comb begin
    st_nxt = st_r;
    if (wr_op) begin
      st_nxt.mem[w_row] = (st_r.mem[w_row] & ~w_bits) | (w_rep & w_bits);
    end
    if (rd_op) begin
      st_nxt.rd_data = r_word;
    end
  end

  // Reset stands for configuration: it loads the preload image
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r.mem <= MEM_INIT;
      st_r.rd_data <= `DPBRAM_RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output taken straight from the read register, no logic after it
  assign rd_data = st_r.rd_data;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dpbram_cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_write_lands: assert property (
    wr_op |=> ((st_r.mem[$past(w_row)] & $past(w_bits)) == ($past(w_rep) & $past(w_bits))))
    else $error("written bits did not land in the array");

  a_mask_protects: assert property (
    (wr_op && shape == DPBRAM_S256X16) |=>
      ((st_r.mem[$past(w_row)] & $past(wq_mask)) == ($past(st_r.mem[w_row]) & $past(wq_mask))))
    else $error("masked bit was overwritten");

  a_idle_stable: assert property (
    !wr_op |=> $stable(st_r.mem))
    else $error("array changed without a write");

  a_read_holds: assert property (
    !rd_op |=> $stable(rd_data))
    else $error("read data moved without a read");

  a_read_value: assert property (
    rd_op |=> rd_data == $past(r_word))
    else $error("read data is not the addressed word");

  a_rise_write: assert property (
    (wr_clk_gate && wr_strobe && !wr_fall) ##1 !wr_fall |-> wr_op)
    else $error("rising write not applied after one edge");

  a_fall_write: assert property (
    (wr_clk_gate && wr_strobe && wr_fall) ##1 wr_fall [*1] ##1 wr_fall |-> wr_op)
    else $error("falling write not applied after two edges");

  a_rd_capture: assert property (
    (rd_clk_gate && !rd_fall) ##1 !rd_fall |-> rd_q == $past(rd_addr))
    else $error("read address not registered at the boundary");

  a_narrow_zero: assert property (
    (rd_op && shape == DPBRAM_S512X8 && $stable(shape)) |=> rd_data[15:8] == 8'h00)
    else $error("upper byte not zero in the 8-bit shape");

endmodule

`default_nettype wire

// [tb/dpbram_user.sv]
// Model of the fabric user logic that drives both RAM ports
`timescale 1ns/1ps
`default_nettype none
`include "dpbram_consts.svh"

module dpbram_user (
  input wire logic clock,
  output logic [`DPBRAM_ADDR_W-1:0] wr_addr,
  output logic [`DPBRAM_DATA_W-1:0] wr_data,
  output logic [`DPBRAM_DATA_W-1:0] wr_mask,
  output logic wr_strobe,
  output logic wr_clk_gate,
  output logic [`DPBRAM_ADDR_W-1:0] rd_addr,
  output logic rd_strobe,
  output logic rd_clk_gate
);
  // Write side starts inactive, so the preload reads back as a ROM
  initial begin
    {wr_addr, wr_data, wr_mask, wr_strobe, wr_clk_gate} = '0;
    {rd_addr, rd_strobe, rd_clk_gate} = '0;
  end

  // Write request, changed just after an edge and held one cycle
  task automatic wr(input logic [10:0] a, input logic [15:0] d, m, input logic s, g);
    @(posedge clock);
    {wr_addr, wr_data, wr_mask, wr_strobe, wr_clk_gate} <= {a, d, m, s, g};
  endtask

  // Read request on its own port, independent of the write side
  task automatic rd(input logic [10:0] a, input logic s, g);
    @(posedge clock);
    {rd_addr, rd_strobe, rd_clk_gate} <= {a, s, g};
  endtask

  // Both sides quiet; write controls off
  task automatic idle();
    @(posedge clock);
    {wr_strobe, wr_clk_gate, rd_strobe, rd_clk_gate} <= 4'h0;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the block RAM over every shape and edge variant
`timescale 1ns/1ps
`default_nettype none
`include "dpbram_consts.svh"

module tb;
  import dpbram_pkg::*;
  // Preload image, alternating row patterns
  localparam logic [`DPBRAM_BITS-1:0] INIT = {128{32'h5a3c_c3a5}};
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  dpbram_shape_t shape = DPBRAM_S256X16;
  dpbram_variant_t variant = DPBRAM_RISING_BOTH;
  logic [10:0] wr_addr, rd_addr;
  logic [15:0] wr_data, wr_mask, rd_data, last, lm;
  logic wr_strobe, wr_clk_gate, rd_strobe, rd_clk_gate;
  logic [15:0] mem [256];
  logic [15:0] exp_q [$];
  logic [10:0] wa [$];
  int due_q [$];
  int cyc = 0;
  int sk = 0;
  int mismatches = 0;
  int checked = 0;

  // 250 MHz clock
  always #2 clock = ~clock;
  // Cycle count, the time base of every read's due date
  always @(posedge clock) cyc <= cyc + 1;

  dpbram_top #(.MEM_INIT(INIT)) u_dut (.clock, .arst_n, .shape, .variant, .wr_addr,
    .wr_data, .wr_mask, .wr_strobe, .wr_clk_gate, .rd_addr, .rd_strobe, .rd_clk_gate,
    .rd_data);
  dpbram_user u_user (.clock, .wr_addr, .wr_data, .wr_mask, .wr_strobe, .wr_clk_gate,
    .rd_addr, .rd_strobe, .rd_clk_gate);

  // ****************************************************************
  // Reference model and drivers
  // ****************************************************************
  // Single judge of every read result; !== so an unknown never passes
  task automatic chk(input logic [15:0] seen, expv);
    checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("[FAIL] %0t rd_data %h expected %h", $time, seen, expv);
    end
  endtask

  // Model updated at once; reads only follow after a settling gap
  task automatic wr(input logic [10:0] a, input logic [15:0] d, m, input logic s, g);
    int r, sh;
    r = a >> sk;
    sh = (a & ((1 << sk) - 1)) * (16 >> sk);
    u_user.wr(a, d, m, s, g);
    if (s && g) begin
      if (sk == 0) mem[r] = (mem[r] & m) | (d & ~m);
      else mem[r] = (mem[r] & ~(lm << sh)) | ((d & lm) << sh);
    end
  endtask

  // A refused read expects the previous word to stay on rd_data
  task automatic rd(input logic [10:0] a, input logic s, g);
    int r, sh;
    r = a >> sk;
    sh = (a & ((1 << sk) - 1)) * (16 >> sk);
    u_user.rd(a, s, g);
    if (s && g) last = (mem[r] >> sh) & lm;
    exp_q.push_back(last);
    due_q.push_back(cyc + 3 + int'(variant[0]));
  endtask

  // Compare each read once its latency has run out
  always @(negedge clock) begin
    if (due_q.size() > 0 && due_q[0] == cyc) begin
      void'(due_q.pop_front());
      chk(rd_data, exp_q.pop_front());
    end
  end

  // Counts, verdict and the end of the run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence: every variant with every shape
  // ****************************************************************
  initial begin
    int a;
    void'($urandom(99));
    repeat (16) @(posedge clock);
    // A read still owed after a test stops both loops and goes to the verdict
    for (int v = 0; v < 4 && due_q.size() == 0; v++) begin
      for (int s = 0; s < 4 && due_q.size() == 0; s++) begin
        // Shape and variant change only while held in reset
        @(posedge clock);
        arst_n <= 1'h0;
        shape <= dpbram_shape_t'(s);
        variant <= dpbram_variant_t'(v);
        @(posedge clock);
        arst_n <= 1'h1;
        sk = s;
        last = '0;
        lm = 16'hffff >> (16 - (16 >> s));
        for (int i = 0; i < 256; i++) mem[i] = INIT[16*i +: 16];
        // Preload read back at both ends, then a refused read
        rd(11'h000, 1'h1, 1'h1);
        rd(11'((256 << s) - 1), 1'h1, 1'h1);
        rd(11'h001, 1'h1, 1'h0);
        for (int i = 0; i < 12; i++) begin
          a = $urandom % (256 << s);
          wa.push_back(a[10:0]);
          wr(a[10:0], 16'($urandom), 16'($urandom), $urandom % 4 != 0, $urandom % 4 != 0);
        end
        repeat (3) u_user.idle();
        foreach (wa[i]) rd(wa[i], $urandom % 4 != 0, 1'h1);
        wa.delete();
        u_user.idle();
        for (int t = 0; t < 10 && due_q.size() > 0; t++) @(posedge clock);
        if (due_q.size() > 0) begin
          mismatches++;
        end
        $display("test shape %0d variant %0d done", s, v);
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
